// ==== rtl/pstn_cfg.svh ====
// Constants of the periodic span-node walker: offsets, field positions,
// reset values and link encodings.
// Assumes it is included by bare name from the package and the modules.
`ifndef PSTN_CFG_SVH
`define PSTN_CFG_SVH

// ****************************************
// Register bus geometry
// ****************************************
`define PSTN_ADDR_W        8
`define PSTN_DATA_W        32
`define PSTN_OFF_CTRL      8'h00
`define PSTN_OFF_FRIDX     8'h04
`define PSTN_OFF_STAT      8'h08
`define PSTN_OFF_SAVED     8'h0c

// ****************************************
// Field positions
// ****************************************
`define PSTN_CTRL_EN       0
`define PSTN_STAT_RECOV    0
`define PSTN_STAT_UF_LO    1
`define PSTN_STAT_UF_HI    3
`define PSTN_STAT_SAVED    4
`define PSTN_FRIDX_W       14
`define PSTN_UF_HI         2
`define PSTN_LINK_T        0

// ****************************************
// Encodings and limits
// ****************************************
`define PSTN_TYP_ITD       2'h0
`define PSTN_TYP_QH        2'h1
`define PSTN_TYP_SITD      2'h2
`define PSTN_TYP_FSTN      2'h3
`define PSTN_LAST_EARLY_UF 3'h1

// ****************************************
// Reset values
// ****************************************
`define PSTN_CTRL_RST      1'h0
`define PSTN_FRIDX_RST     14'h0000
`define PSTN_PTR_RST       32'h0000_0000
`define PSTN_RD_RST        32'h0000_0000

`endif

// ==== rtl/pstn_pkg.sv ====
// Types and helper functions shared by the span-node walker files.
// Assumes pstn_cfg.svh is on the include path.
`include "pstn_cfg.svh"

package pstn_pkg;

   // ****************************************
   // Schedule element kinds
   // ****************************************
   typedef enum logic [1:0] {
      PSTN_ITD  = `PSTN_TYP_ITD,
      PSTN_QH   = `PSTN_TYP_QH,
      PSTN_SITD = `PSTN_TYP_SITD,
      PSTN_FSTN = `PSTN_TYP_FSTN
   } pstn_ntype_t;

   // One fetched schedule element, as presented by the fetch engine
   typedef struct packed {
      pstn_ntype_t               nodeType;      // Element kind
      logic [`PSTN_DATA_W-1:0]   normalLink;    // Normal / next / horizontal link
      logic [`PSTN_DATA_W-1:0]   backLink;      // Back path link (span node only)
      logic                      highSpeed;     // Endpoint speed field says high speed
      logic                      splitComplete; // Split phase bit is in complete phase
      logic                      execReady;     // Usual execution conditions met
      logic                      sMaskHit;      // Start mask matches micro-frame
      logic                      cMaskHit;      // Complete mask matches micro-frame
   } pstn_node_t;

   // Traversal decision for one element
   typedef struct packed {
      logic [`PSTN_DATA_W-1:0]   nextLink;      // Pointer to fetch next
      logic                      endList;       // Periodic list ends here
      logic                      doExec;        // Plain transaction may run
      logic                      doStart;       // Start-split may run
      logic                      doComplete;    // Complete-split may run
   } pstn_step_t;

   // Register bus request carrier
   typedef struct packed {
      logic                      wr;
      logic                      rd;
      logic [`PSTN_ADDR_W-1:0]   addr;
      logic [`PSTN_DATA_W-1:0]   wdata;
   } pstn_busreq_t;

   // Micro-frame number from the frame index
   function automatic logic [`PSTN_UF_HI:0] pstnUFrame(input logic [`PSTN_FRIDX_W-1:0] idx);
      return idx[`PSTN_UF_HI:0];
   endfunction : pstnUFrame

   // Terminate flag of a link pointer
   function automatic logic pstnLinkEnds(input logic [`PSTN_DATA_W-1:0] link);
      return link[`PSTN_LINK_T];
   endfunction : pstnLinkEnds

endpackage : pstn_pkg

// ==== rtl/pstn_save_slot.sv ====
// Holder for the saved normal-path pointer of a save-place node.
// Assumes store and clear come from logic on the same clock.
`include "pstn_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module pstn_save_slot
   import pstn_pkg::*;
(
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // Control
   input  wire logic                    clear,
   input  wire logic                    store,
   input  wire logic [`PSTN_DATA_W-1:0] dIn,
   // Held value
   output var  logic [`PSTN_DATA_W-1:0] q,
   output var  logic                    held
);

   // ****************************************
   // Pointer store
   // ****************************************
   // Clear wins so a frame start never keeps a stale pointer
   always_ff @(posedge sys_clk) begin
      if (rst || clear) begin
         q    <= `PSTN_PTR_RST;
         held <= 1'b0;
      end else if (store) begin
         q    <= dIn;
         held <= 1'b1;
      end
   end

endmodule : pstn_save_slot

`default_nettype wire

// ==== rtl/pstn_walker.sv ====
// Span-node traversal logic of the periodic schedule walker.
// Assumes the fetch engine presents one element at a time with nodeValid,
// on the same clock, and raises uFrameStart before the frame list fetch.
// Summary of operation
// - Micro-frames 2-7: span node takes normal path
// - Normal link terminate flag ends periodic list
// - Back terminate zero save-place, one restore
// - Save-place in frames 0-1: store, flag, go back
// - Recovering: save-place passed by normal path
// - Recovering: isochronous descriptors skipped, not run
// - Recovering: high-speed queue heads skipped
// - Recovering: full/low queue head needs complete phase
// - No start-split while recovering
// - Restore while recovering: clear flag, resume saved
// - Out of time: abandon recovery, clear context
// - Restore when not recovering: normal path
// - Micro-frame from frame index low bits
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`include "pstn_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module pstn_walker
   import pstn_pkg::*;
(
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // Register port
   input  wire pstn_busreq_t            busReq,
   output var  logic [`PSTN_DATA_W-1:0] rdData,
   // Frame timing from the frame engine
   input  wire logic                    uFrameStart,
   input  wire logic                    timeShort,
   // Element from the fetch engine
   input  wire logic                    nodeValid,
   input  wire pstn_node_t              nodeIn,
   output logic                         nodeReady,
   // Decision to the fetch and execute engines
   output var  logic                    stepValid,
   output var  pstn_step_t              step,
   output var  logic                    inRecovery
);

   // ****************************************
   // Registers and state
   // ****************************************
   logic                      enable_ff;       // Walker enable from software
   logic [`PSTN_FRIDX_W-1:0]  frameIdx_ff;     // Frame index register
   logic [`PSTN_DATA_W-1:0]   rdData_ff;       // Read data, one cycle late
   logic                      recov_ff;        // Recovery-path flag
   logic                      nxt_recov;       // Next recovery flag
   logic                      stepValid_ff;    // Decision present
   pstn_step_t                step_ff;         // Registered decision
   pstn_step_t                nxt_step;        // Decision being formed
   logic [`PSTN_DATA_W-1:0]   savedPtr;        // Stored save-place pointer
   logic                      savedHeld;       // Stored pointer present
   logic                      storeSave;       // Capture the pointer now
   logic                      ctxClear;        // Drop the recovery context
   logic                      restoreNow;      // Restore taken while recovering

   // ****************************************
   // Element classification
   // ****************************************
   logic [`PSTN_UF_HI:0]      uFrame;          // Current micro-frame
   logic                      earlyUf;         // Micro-frame 0 or 1
   logic                      isFstn;          // Element is a span node
   logic                      isSave;          // Save-place span node
   logic                      isRestore;       // Restore span node
   logic                      take;            // Element accepted this cycle

   assign uFrame    = pstnUFrame(frameIdx_ff);
   assign earlyUf   = (uFrame <= `PSTN_LAST_EARLY_UF);
   assign isFstn    = (nodeIn.nodeType == PSTN_FSTN);
   assign isSave    = isFstn && !pstnLinkEnds(nodeIn.backLink);
   assign isRestore = isFstn && pstnLinkEnds(nodeIn.backLink);

   // Frame start and time-out take priority, so no element is taken then
   assign nodeReady = enable_ff && !uFrameStart && !timeShort;
   assign take      = nodeValid && nodeReady;

   // context clear sources
   // Abandon also covers uFrameStart, so the next frame restarts cleanly
   assign ctxClear  = uFrameStart || timeShort;
   // restore drops the saved pointer with the flag
   // Otherwise a later read in the same frame could report a pointer that is no longer in use
   assign restoreNow = take && isRestore && recov_ff;

   // ****************************************
   // Traversal decision
   // ****************************************
   // One element in, one decision out; the fetch engine waits on stepValid
   always_comb begin
      nxt_step   = '0;
      nxt_recov  = recov_ff;
      storeSave  = 1'b0;
      nxt_step.nextLink = nodeIn.normalLink;
      unique case (nodeIn.nodeType)
         PSTN_FSTN: begin
            if (isSave && earlyUf && !recov_ff) begin
               nxt_step.nextLink = nodeIn.backLink;
               nxt_recov         = 1'b1;
               storeSave         = 1'b1;
            end else if (isRestore && recov_ff) begin
               nxt_step.nextLink = savedPtr;
               nxt_recov         = 1'b0;
            end else begin
               nxt_step.nextLink = nodeIn.normalLink;
            end
         end
         PSTN_ITD, PSTN_SITD: begin
            nxt_step.doExec = !recov_ff && nodeIn.execReady;
         end
         PSTN_QH: begin
            if (nodeIn.highSpeed) begin
               nxt_step.doExec = !recov_ff && nodeIn.execReady;
            end else begin
               nxt_step.doComplete = nodeIn.splitComplete && nodeIn.cMaskHit && nodeIn.execReady;
               nxt_step.doStart = !recov_ff && !nodeIn.splitComplete && nodeIn.sMaskHit
                                  && nodeIn.execReady;
            end
         end
      endcase
      nxt_step.endList = pstnLinkEnds(nxt_step.nextLink);
   end

   // ****************************************
   // Recovery flag
   // ****************************************
   // abandon on time-out
   always_ff @(posedge sys_clk) begin
      if (rst || ctxClear) begin
         recov_ff <= 1'b0;
      end else if (take) begin
         recov_ff <= nxt_recov;
      end
   end

   // Saved pointer lives in its own slot, cleared with the flag
   pstn_save_slot u_slot (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clear   (ctxClear || restoreNow),
      .store   (take && storeSave),
      .dIn     (nodeIn.normalLink),
      .q       (savedPtr),
      .held    (savedHeld)
   );

   // ****************************************
   // Decision output
   // ****************************************
   // Registered so the fetch engine sees stable pointers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stepValid_ff <= 1'b0;
         step_ff      <= '0;
      end else begin
         stepValid_ff <= take;
         if (take) begin
            step_ff <= nxt_step;
         end
      end
   end

   assign stepValid  = stepValid_ff;
   assign step       = step_ff;
   assign inRecovery = recov_ff;

   // ****************************************
   // Control register
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         enable_ff <= `PSTN_CTRL_RST;
      end else if (busReq.wr && busReq.addr == `PSTN_OFF_CTRL) begin
         enable_ff <= busReq.wdata[`PSTN_CTRL_EN];
      end
   end

   // ****************************************
   // Frame index register
   // ****************************************
   // A software write wins over the micro-frame advance
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         frameIdx_ff <= `PSTN_FRIDX_RST;
      end else if (busReq.wr && busReq.addr == `PSTN_OFF_FRIDX) begin
         frameIdx_ff <= busReq.wdata[`PSTN_FRIDX_W-1:0];
      end else if (uFrameStart) begin
         frameIdx_ff <= frameIdx_ff + `PSTN_FRIDX_W'(1);
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   // Unmapped offsets read as zero; data stand one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdData_ff <= `PSTN_RD_RST;
      end else if (busReq.rd) begin
         rdData_ff <= '0;
         unique case (busReq.addr)
            `PSTN_OFF_CTRL: begin
               rdData_ff[`PSTN_CTRL_EN] <= enable_ff;
            end
            `PSTN_OFF_FRIDX: begin
               rdData_ff[`PSTN_FRIDX_W-1:0] <= frameIdx_ff;
            end
            `PSTN_OFF_STAT: begin
               rdData_ff[`PSTN_STAT_RECOV]                   <= recov_ff;
               rdData_ff[`PSTN_STAT_UF_HI:`PSTN_STAT_UF_LO] <= uFrame;
               rdData_ff[`PSTN_STAT_SAVED]                   <= savedHeld;
            end
            `PSTN_OFF_SAVED: begin
               rdData_ff <= savedPtr;
            end
            default: begin
               rdData_ff <= '0;
            end
         endcase
      end else begin
         rdData_ff <= '0;
      end
   end

   assign rdData = rdData_ff;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Element taken while recovering / not recovering
   sequence s_takeRecov;
      take && recov_ff;
   endsequence
   sequence s_takeNormal;
      take && !recov_ff;
   endsequence

   property p_lateNormal;
      (take && isFstn && !earlyUf) |=> step_ff.nextLink == $past(nodeIn.normalLink);
   endproperty
   a_lateNormal: assert property (p_lateNormal)
      else $error("Span node in late micro-frame left the normal path");

   property p_endMark;
      stepValid_ff |-> step_ff.endList == step_ff.nextLink[`PSTN_LINK_T];
   endproperty
   a_endMark: assert property (p_endMark)
      else $error("End-of-list mark disagrees with the link terminate flag");

   // Span node on its normal path ends the list when that link terminates
   property p_endNormal;
      (take && isFstn && !(isSave && earlyUf && !recov_ff) && !(isRestore && recov_ff))
         |=> step_ff.endList == $past(nodeIn.normalLink[`PSTN_LINK_T]);
   endproperty
   a_endNormal: assert property (p_endNormal)
      else $error("Normal path terminate flag did not end the list");

   property p_saveEnter;
      s_takeNormal ##0 (isSave && earlyUf) |=> recov_ff && savedHeld
         && savedPtr == $past(nodeIn.normalLink) && step_ff.nextLink == $past(nodeIn.backLink);
   endproperty
   a_saveEnter: assert property (p_saveEnter)
      else $error("Save-place node did not enter recovery correctly");

   property p_noNest;
      s_takeRecov ##0 isSave |=> recov_ff && step_ff.nextLink == $past(nodeIn.normalLink)
         && savedPtr == $past(savedPtr);
   endproperty
   a_noNest: assert property (p_noNest)
      else $error("Back path followed while recovering");

   property p_isoSkip;
      s_takeRecov ##0 (nodeIn.nodeType == PSTN_ITD || nodeIn.nodeType == PSTN_SITD)
         |=> !step_ff.doExec && step_ff.nextLink == $past(nodeIn.normalLink);
   endproperty
   a_isoSkip: assert property (p_isoSkip)
      else $error("Isochronous descriptor run in recovery");

   property p_hsSkip;
      s_takeRecov ##0 (nodeIn.nodeType == PSTN_QH && nodeIn.highSpeed)
         |=> !(step_ff.doExec || step_ff.doStart || step_ff.doComplete);
   endproperty
   a_hsSkip: assert property (p_hsSkip)
      else $error("High-speed queue head run in recovery");

   property p_fsComplete;
      s_takeRecov ##0 (nodeIn.nodeType == PSTN_QH && !nodeIn.highSpeed && !nodeIn.splitComplete)
         |=> !step_ff.doComplete && !step_ff.doExec;
   endproperty
   a_fsComplete: assert property (p_fsComplete)
      else $error("Queue head outside complete phase run in recovery");

   // An eligible complete phase must still run while recovering
   property p_fsRun;
      s_takeRecov ##0 (nodeIn.nodeType == PSTN_QH && !nodeIn.highSpeed && nodeIn.splitComplete
         && nodeIn.cMaskHit && nodeIn.execReady) |=> step_ff.doComplete && !step_ff.doStart;
   endproperty
   a_fsRun: assert property (p_fsRun)
      else $error("Eligible complete-split refused in recovery");

   property p_noStart;
      s_takeRecov |=> !step_ff.doStart;
   endproperty
   a_noStart: assert property (p_noStart)
      else $error("Start-split allowed while recovering");

   property p_restore;
      s_takeRecov ##0 isRestore |=> !recov_ff && step_ff.nextLink == $past(savedPtr) ##1 !savedHeld;
   endproperty
   a_restore: assert property (p_restore)
      else $error("Restore node did not resume at the saved pointer");

   property p_abandon;
      timeShort |=> !recov_ff && !savedHeld && !stepValid_ff;
   endproperty
   a_abandon: assert property (p_abandon)
      else $error("Recovery context kept after time ran out");

   property p_restorePass;
      s_takeNormal ##0 isRestore |=> !recov_ff && step_ff.nextLink == $past(nodeIn.normalLink);
   endproperty
   a_restorePass: assert property (p_restorePass)
      else $error("Restore node outside recovery left the normal path");

   property p_frameClear;
      uFrameStart |=> !recov_ff && savedPtr == `PSTN_PTR_RST && !savedHeld;
   endproperty
   a_frameClear: assert property (p_frameClear)
      else $error("Recovery context survived a micro-frame start");

endmodule : pstn_walker

`default_nettype wire

// ==== test/pstn_sched_model.sv ====
// Partner model: fetch side of the walker, reading a small schedule built
// the way system software must build it, and following each decision.
// Assumes the walker's clock and reset; link bits [7:5] index the table.
`include "pstn_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module pstn_sched_model
   import pstn_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Walk control from the bench
   input  wire logic       start,
   input  wire logic [2:0] startIdx,
   // Walker handshake
   input  wire logic       nodeReady,
   input  wire logic       stepValid,
   input  wire pstn_step_t step,
   output var  logic       nodeValid,
   output var  pstn_node_t nodeIn
);
   // ****************************************
   // Schedule memory
   // ****************************************
   pstn_node_t mem [8];   // Elements by index
   logic [2:0] cur;       // Element being fetched
   logic [1:0] cnt;       // Fetch latency countdown
   logic       waitStep;  // Taken, decision pending

   function automatic logic [31:0] lk(input logic [2:0] i, input logic [1:0] t, input logic e);
      return {24'h0, i, 2'b00, t, e};
   endfunction : lk

   function automatic pstn_node_t mk(input logic [1:0] t, input logic [31:0] nl, input logic [31:0] bl,
                                     input logic [4:0] f);
      return '{pstn_ntype_t'(t), nl, bl, f[4], f[3], f[2], f[1], f[0]};
   endfunction : mk

   // save paired with restore
   // Save node backs into a QH; restore ends the list (no rate-one list)
   // all paths meet at the restore node; one save node
   // the table never changes during a walk
   initial begin
      mem[0] = mk(2'h0, lk(3'h7, 2'h2, 1'b0), 32'h1, 5'h04);
      mem[1] = mk(2'h1, lk(3'h2, 2'h3, 1'b0), 32'h1, 5'h07);
      mem[2] = mk(2'h3, lk(3'h5, 2'h1, 1'b0), lk(3'h3, 2'h1, 1'b0), 5'h00);
      mem[3] = mk(2'h1, lk(3'h4, 2'h1, 1'b0), 32'h1, 5'h0d);
      mem[4] = mk(2'h1, lk(3'h0, 2'h0, 1'b0), 32'h1, 5'h14);
      mem[5] = mk(2'h1, lk(3'h6, 2'h3, 1'b0), 32'h1, 5'h06);
      mem[6] = mk(2'h3, 32'h1, 32'h1, 5'h00);
      mem[7] = mk(2'h2, lk(3'h6, 2'h3, 1'b0), 32'h1, 5'h04);
   end

   // Released bus shows the inverse of the element, never a stale copy
   always_comb nodeIn = nodeValid ? mem[cur] : ~mem[cur];

   // ****************************************
   // Fetch sequencing
   // ****************************************
   // Two-cycle fetch, like a memory read; also lets the bench stall the walk
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cur       <= 3'h0;
         nodeValid <= 1'b0;
         waitStep  <= 1'b0;
         cnt       <= 2'h0;
      end else if (start) begin
         cur <= startIdx;
         cnt <= 2'h2;
      end else if (nodeValid && nodeReady) begin
         nodeValid <= 1'b0;
         waitStep  <= 1'b1;
      end else if (waitStep && stepValid) begin
         waitStep <= 1'b0;
         // End of list stops the walk
         if (!step.endList) begin
            cur <= step.nextLink[7:5];
            cnt <= 2'h2;
         end
      end else if (cnt != 2'h0) begin
         cnt <= cnt - 2'h1;
         if (cnt == 2'h1) begin
            nodeValid <= 1'b1;
         end
      end
   end
endmodule : pstn_sched_model
`default_nettype wire

// ==== test/tb_periodic_span_node_traversal.sv ====
// Self-checking bench of the span-node walker: register port tasks and
// schedule walks in micro-frames 0, 1 and 2, with an abandoned recovery.
// Assumes the walker, its package and the partner schedule model.
`include "pstn_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_periodic_span_node_traversal
   import pstn_pkg::*;
;
   // ****************************************
   // Signals
   // ****************************************
   logic         sys_clk, rst, uFrameStart, timeShort, nodeValid, nodeReady;
   logic         stepValid, inRecovery, start;
   logic [2:0]   startIdx;
   logic [31:0]  rdData;
   pstn_busreq_t busReq;
   pstn_node_t   nodeIn;
   pstn_step_t   step;
   int           errors, num_checks;

   pstn_walker i_dut (.sys_clk(sys_clk), .rst(rst), .busReq(busReq), .rdData(rdData),
      .uFrameStart(uFrameStart), .timeShort(timeShort), .nodeValid(nodeValid), .nodeIn(nodeIn),
      .nodeReady(nodeReady), .stepValid(stepValid), .step(step), .inRecovery(inRecovery));
   pstn_sched_model i_sched (.sys_clk(sys_clk), .rst(rst), .start(start), .startIdx(startIdx),
      .nodeReady(nodeReady), .stepValid(stepValid), .step(step), .nodeValid(nodeValid), .nodeIn(nodeIn));

   // 250 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // ****************************************
   // Tasks
   // ****************************************
   function automatic logic [31:0] lk(input logic [2:0] i, input logic [1:0] t);
      return {24'h0, i, 2'b00, t, 1'b0};
   endfunction : lk

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
      end
   endtask : chk32

   task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk) busReq <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk) busReq <= '0;
   endtask : wrReg

   // Data stand one cycle only, then zero
   task automatic rdReg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk) busReq <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge sys_clk) busReq <= '0;
      #1 chk32(rdData, exp);
      @(posedge sys_clk) #1 chk32(rdData, 32'h0);
   endtask : rdReg

   task automatic chkStep(input logic [31:0] nl, input logic [4:0] f);
      pstn_step_t e;
      int         k;
      e = '{nl, nl[0], f[4], f[3], f[2]};
      for (k = 0; k < 40; k++) begin
         @(posedge sys_clk) #1;
         if (stepValid === 1'b1) break;
      end
      num_checks++;
      if (k == 40 || step !== e || inRecovery !== f[0]) begin
         errors++;
         $display("unexpected at %0t: step %h rec %b, wanted %h rec %b", $time, step, inRecovery, e, f[0]);
      end
   endtask : chkStep

   task automatic walk(input logic [2:0] i);
      @(posedge sys_clk) {start, startIdx} <= {1'b1, i};
      @(posedge sys_clk) start <= 1'b0;
   endtask : walk

   task automatic pulse(input bit which);
      @(posedge sys_clk) if (which) timeShort <= 1'b1; else uFrameStart <= 1'b1;
      @(posedge sys_clk) {timeShort, uFrameStart} <= 2'b00;
   endtask : pulse

   // ****************************************
   // Watchdog
   // ****************************************
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      $display("unexpected at %0t: run hung", $time);
      close_out();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   // f = {doExec, doStart, doComplete, unused, inRecovery}
   initial begin
      {rst, uFrameStart, timeShort, start, startIdx, busReq} = '0;
      errors = 0;
      num_checks = 0;
      rst = 1'b1;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      rdReg(`PSTN_OFF_CTRL, 32'h0);
      rdReg(`PSTN_OFF_SAVED, 32'h0);
      rdReg(8'h10, 32'h0);
      wrReg(`PSTN_OFF_STAT, 32'hffff_ffff);
      rdReg(`PSTN_OFF_STAT, 32'h0);
      wrReg(`PSTN_OFF_CTRL, 32'h1);
      rdReg(`PSTN_OFF_CTRL, 32'h1);
      // Micro-frame 0: full recovery path
      walk(3'h1);
      chkStep(lk(3'h2, 2'h3), 5'h08);
      chkStep(lk(3'h3, 2'h1), 5'h01);
      chkStep(lk(3'h4, 2'h1), 5'h05);
      chkStep(lk(3'h0, 2'h0), 5'h01);
      chkStep(lk(3'h7, 2'h2), 5'h01);
      chkStep(lk(3'h6, 2'h3), 5'h01);
      chkStep(lk(3'h5, 2'h1), 5'h00);
      chkStep(lk(3'h6, 2'h3), 5'h08);
      chkStep(32'h1, 5'h00);
      // Micro-frame 2: save node passed on normal path
      wrReg(`PSTN_OFF_FRIDX, 32'h2);
      rdReg(`PSTN_OFF_STAT, 32'h4);
      walk(3'h1);
      chkStep(lk(3'h2, 2'h3), 5'h08);
      chkStep(lk(3'h5, 2'h1), 5'h00);
      chkStep(lk(3'h6, 2'h3), 5'h08);
      chkStep(32'h1, 5'h00);
      repeat (6) pulse(1'b0);
      rdReg(`PSTN_OFF_FRIDX, 32'h8);
      rdReg(`PSTN_OFF_STAT, 32'h0);
      // Micro-frame 0 again, recovery abandoned when time runs short
      walk(3'h1);
      chkStep(lk(3'h2, 2'h3), 5'h08);
      chkStep(lk(3'h3, 2'h1), 5'h01);
      wrReg(`PSTN_OFF_CTRL, 32'h0);
      rdReg(`PSTN_OFF_SAVED, lk(3'h5, 2'h1));
      rdReg(`PSTN_OFF_STAT, 32'h11);
      pulse(1'b1);
      rdReg(`PSTN_OFF_STAT, 32'h0);
      rdReg(`PSTN_OFF_SAVED, 32'h0);
      wrReg(`PSTN_OFF_CTRL, 32'h1);
      chkStep(lk(3'h4, 2'h1), 5'h04);
      chkStep(lk(3'h0, 2'h0), 5'h10);
      chkStep(lk(3'h7, 2'h2), 5'h10);
      chkStep(lk(3'h6, 2'h3), 5'h10);
      chkStep(32'h1, 5'h00);
      // Micro-frame 1: recovery entered, then a save node met while recovering
      pulse(1'b0);
      rdReg(`PSTN_OFF_STAT, 32'h2);
      walk(3'h1);
      chkStep(lk(3'h2, 2'h3), 5'h08);
      chkStep(lk(3'h3, 2'h1), 5'h01);
      wrReg(`PSTN_OFF_CTRL, 32'h0);
      walk(3'h2);
      wrReg(`PSTN_OFF_CTRL, 32'h1);
      chkStep(lk(3'h5, 2'h1), 5'h01);
      chkStep(lk(3'h6, 2'h3), 5'h01);
      chkStep(lk(3'h5, 2'h1), 5'h00);
      chkStep(lk(3'h6, 2'h3), 5'h08);
      chkStep(32'h1, 5'h00);
      close_out();
   end
endmodule : tb_periodic_span_node_traversal
`default_nettype wire
